// ===== rtl/hcs_pkg.sv
// constants, register map and state encoding for the hub config strap block
package hcs_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned OSC_REF_HZ    = 24_000_000;
	localparam int unsigned AXI_AW        = 4;
	localparam int unsigned SYNC_W        = 6;

	// configuration-method codes, {bit1, bit0}
	localparam logic [1:0] CODE_RSVD      = 2'h0;
	localparam logic [1:0] CODE_SMBUS     = 2'h1;
	localparam logic [1:0] CODE_DEFAULT   = 2'h2;
	localparam logic [1:0] CODE_EEPROM    = 2'h3;

	localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2c;

	// register byte offsets
	localparam logic [3:0] OFS_CTRL       = 4'h0;
	localparam logic [3:0] OFS_STATUS     = 4'h4;
	localparam logic [3:0] OFS_SLVADDR    = 4'h8;
	localparam logic [3:0] OFS_REFCLK     = 4'hc;

	// control fields
	localparam int unsigned CTRL_PORT_EN  = 0;
	localparam int unsigned CTRL_RESAMPLE = 1;
	localparam logic        CTRL_PORT_EN_RST = 1'b1;

	// status fields
	localparam int unsigned STS_CODE_LSB  = 0;
	localparam int unsigned STS_VALID     = 2;
	localparam int unsigned STS_RSVD_ERR  = 3;
	localparam int unsigned STS_EXT_CLK   = 4;
	localparam int unsigned STS_SUPPLY    = 5;
	localparam int unsigned STS_LOCAL_SUPPLY_DETECT  = 6;
	localparam int unsigned STS_TEST_SEEN = 7;

	// sync vector bit positions
	localparam int unsigned SY_SEL0       = 0;
	localparam int unsigned SY_SEL1       = 1;
	localparam int unsigned SY_EXTCLK     = 2;
	localparam int unsigned SY_SUPPLY     = 3;
	localparam int unsigned SY_TEST       = 4;
	localparam int unsigned SY_SDA        = 5;

	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	typedef enum logic [2:0] {
		ST_HOLD   = 3'h1,
		ST_SAMPLE = 3'h2,
		ST_ACTIVE = 3'h4
	} hcs_state_e;
endpackage

// ===== rtl/hcs_sync.sv
// two-flop synchroniser for board pins
`timescale 1ns/1ps
module hcs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         aclk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	initial begin
		if (W < 1) $error("hcs_sync: W must be at least 1");
	end

	// no reset: straps must be visible on the cycle reset releases
	always_ff @(posedge aclk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

// ===== rtl/hcs_axil.sv
// axi4-lite slave front end with a simple register port
`timescale 1ns/1ps
module hcs_axil #(
	parameter int unsigned AW = 4
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] awaddr,
	input  wire logic          awvalid,
	output logic               awready,
	input  wire logic [31:0]   wdata,
	input  wire logic [3:0]    wstrb,
	input  wire logic          wvalid,
	output logic               wready,
	output logic [1:0]         bresp,
	output logic               bvalid,
	input  wire logic          bready,
	input  wire logic [AW-1:0] araddr,
	input  wire logic          arvalid,
	output logic               arready,
	output logic [31:0]        rdata,
	output logic [1:0]         rresp,
	output logic               rvalid,
	input  wire logic          rready,
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [31:0]        wr_data,
	output logic [3:0]         wr_strb,
	input  wire logic          wr_ok,
	output logic [AW-1:0]      rd_addr,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_ok
);
	localparam logic [1:0] RESP_OKAY_C = hcs_pkg::RESP_OKAY;
	localparam logic [1:0] RESP_ERR_C  = hcs_pkg::RESP_SLVERR;

	logic          aw_full_r;
	logic          w_full_r;
	logic [AW-1:0] awaddr_r;
	logic [31:0]   wdata_r;
	logic [3:0]    wstrb_r;
	wire           aw_take = awvalid & awready;
	wire           w_take  = wvalid & wready;
	wire           aw_have = aw_full_r | aw_take;
	wire           w_have  = w_full_r | w_take;
	wire           do_wr   = aw_have & w_have;
	wire           b_nxt   = do_wr | (bvalid & ~bready);
	wire           awf_nxt = aw_have & ~do_wr;
	wire           wf_nxt  = w_have & ~do_wr;
	wire           ar_take = arvalid & arready;
	wire           r_nxt   = ar_take | (rvalid & ~rready);

	initial begin
		if (AW < 4) $error("hcs_axil: AW must be at least 4");
	end

	assign wr_en   = do_wr;
	assign wr_addr = aw_take ? awaddr : awaddr_r;
	assign wr_data = w_take ? wdata : wdata_r;
	assign wr_strb = w_take ? wstrb : wstrb_r;
	assign rd_addr = araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY_C;
		end else begin
			aw_full_r <= awf_nxt;
			w_full_r  <= wf_nxt;
			awready   <= ~awf_nxt & ~b_nxt;
			wready    <= ~wf_nxt & ~b_nxt;
			bvalid    <= b_nxt;
			if (do_wr) bresp <= wr_ok ? RESP_OKAY_C : RESP_ERR_C;
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take) awaddr_r <= awaddr;
		if (w_take) begin
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY_C;
		end else begin
			arready <= ~r_nxt;
			rvalid  <= r_nxt;
			if (ar_take) begin
				rdata <= rd_ok ? rd_data : 32'h0000_0000;
				rresp <= rd_ok ? RESP_OKAY_C : RESP_ERR_C;
			end
		end
	end
endmodule

// ===== rtl/hcs_strap_select.sv
// configuration-method strap capture, clock-source and power-source decode
`timescale 1ns/1ps
module hcs_strap_select (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        serial_port_clock_in,
	output logic             serial_port_clock_out,
	output logic             serial_port_clock_oe_n,
	input  wire logic        serial_port_data_in,
	output logic             serial_port_data_out,
	output logic             serial_port_data_oe_n,
	input  wire logic        config_method_bit1,
	input  wire logic        ext_clock_select,
	input  wire logic        local_supply_detect,
	input  wire logic        test_pin,
	input  wire logic        engine_clock_pull_low,
	input  wire logic        engine_data_pull_low,
	input  wire logic        dl_self_powered,
	input  wire logic        dl_current_ganged,
	output logic             serial_clock_rx,
	output logic             serial_data_rx,
	output logic [1:0]       cfg_method,
	output logic             cfg_valid,
	output logic             smbus_slave_mode,
	output logic [6:0]       smbus_slave_addr,
	output logic             default_cfg_mode,
	output logic             eeprom_cfg_mode,
	output logic             cfg_reserved_error,
	output logic             osc_ext_clock,
	output logic             osc_amp_enable,
	output logic             self_powered,
	output logic             current_sense_ganged
);
	localparam int unsigned AW = hcs_pkg::AXI_AW;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	function automatic logic code_is(input logic [1:0] code, input logic [1:0] want);
		code_is = (code == want);
	endfunction

	// pins from the board cross into aclk first
	logic [hcs_pkg::SYNC_W-1:0] pins_w;
	logic [hcs_pkg::SYNC_W-1:0] pins_s;

	assign pins_w[hcs_pkg::SY_SEL0]   = serial_port_clock_in;
	assign pins_w[hcs_pkg::SY_SEL1]   = config_method_bit1;
	assign pins_w[hcs_pkg::SY_EXTCLK] = ext_clock_select;
	assign pins_w[hcs_pkg::SY_SUPPLY] = local_supply_detect;
	assign pins_w[hcs_pkg::SY_TEST]   = test_pin;
	assign pins_w[hcs_pkg::SY_SDA]    = serial_port_data_in;

	hcs_sync #(
		.W (hcs_pkg::SYNC_W)
	) u_sync (
		.aclk (aclk),
		.d    (pins_w),
		.q    (pins_s)
	);

	wire sel0_s   = pins_s[hcs_pkg::SY_SEL0];
	wire sel1_s   = pins_s[hcs_pkg::SY_SEL1];
	wire extclk_s = pins_s[hcs_pkg::SY_EXTCLK];
	wire supply_s = pins_s[hcs_pkg::SY_SUPPLY];
	wire test_s   = pins_s[hcs_pkg::SY_TEST];

	assign serial_clock_rx = sel0_s;
	assign serial_data_rx  = pins_s[hcs_pkg::SY_SDA];

	// register port
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [31:0]   wr_data;
	logic [3:0]    wr_strb;
	logic [AW-1:0] rd_addr;
	logic [31:0]   rd_data;
	logic          rd_ok;
	logic          wr_ok;

	hcs_axil #(
		.AW (AW)
	) u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	wire [3:0] wr_word = {wr_addr[3:2], 2'b00};
	wire [3:0] rd_word = {rd_addr[3:2], 2'b00};
	wire       wr_ctrl = wr_en & (wr_word == hcs_pkg::OFS_CTRL) & wr_strb[0];

	// only the control word takes writes; others answer slverr
	assign wr_ok = (wr_word == hcs_pkg::OFS_CTRL);

	logic                port_en_r;
	logic                test_seen_r;
	hcs_pkg::hcs_state_e state_r;
	hcs_pkg::hcs_state_e state_nxt;
	wire                 resample = wr_ctrl & wr_data[hcs_pkg::CTRL_RESAMPLE];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_en_r <= hcs_pkg::CTRL_PORT_EN_RST;
		end else if (wr_ctrl) begin
			port_en_r <= wr_data[hcs_pkg::CTRL_PORT_EN];
		end
	end

	// capture sequence: hold in reset, sample once on release, then run
	always_comb begin
		case (state_r)
			hcs_pkg::ST_HOLD:   state_nxt = hcs_pkg::ST_SAMPLE;
			hcs_pkg::ST_SAMPLE: state_nxt = hcs_pkg::ST_ACTIVE;
			hcs_pkg::ST_ACTIVE: state_nxt = resample ? hcs_pkg::ST_SAMPLE : hcs_pkg::ST_ACTIVE;
			default:            state_nxt = hcs_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) state_r <= hcs_pkg::ST_HOLD;
		else          state_r <= state_nxt;
	end

	wire sampling = (state_r == hcs_pkg::ST_SAMPLE);
	wire active   = (state_r == hcs_pkg::ST_ACTIVE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_method    <= hcs_pkg::CODE_RSVD;
			cfg_valid     <= 1'b0;
			osc_ext_clock <= 1'b0;
			osc_amp_enable <= 1'b1;
		end else if (sampling) begin
			cfg_method[0]  <= sel0_s;
			cfg_method[1]  <= sel1_s;
			cfg_valid      <= 1'b1;
			osc_ext_clock  <= extclk_s;
			osc_amp_enable <= ~extclk_s;
		end
	end

	wire is_smbus   = cfg_valid & code_is(cfg_method, hcs_pkg::CODE_SMBUS);
	wire is_default = cfg_valid & code_is(cfg_method, hcs_pkg::CODE_DEFAULT);
	wire is_eeprom  = cfg_valid & code_is(cfg_method, hcs_pkg::CODE_EEPROM);
	wire is_rsvd    = cfg_valid & code_is(cfg_method, hcs_pkg::CODE_RSVD);
	// serial port only used by download methods, never while sampling
	wire port_use   = active & port_en_r & (is_smbus | is_eeprom);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smbus_slave_mode   <= 1'b0;
			smbus_slave_addr   <= 7'h00;
			default_cfg_mode   <= 1'b0;
			eeprom_cfg_mode    <= 1'b0;
			cfg_reserved_error <= 1'b0;
		end else begin
			smbus_slave_mode   <= is_smbus;
			smbus_slave_addr   <= is_smbus ? hcs_pkg::SMBUS_SLAVE_ADDR : 7'h00;
			default_cfg_mode   <= is_default;
			eeprom_cfg_mode    <= is_eeprom;
			cfg_reserved_error <= is_rsvd;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			self_powered         <= 1'b0;
			current_sense_ganged <= 1'b0;
		end else begin
			self_powered         <= default_cfg_mode ? supply_s : dl_self_powered;
			current_sense_ganged <= default_cfg_mode ? supply_s : dl_current_ganged;
		end
	end

	// open-drain: out stays low, oe_n low pulls the line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_port_clock_out  <= 1'b0;
			serial_port_data_out   <= 1'b0;
			serial_port_clock_oe_n <= 1'b1;
			serial_port_data_oe_n  <= 1'b1;
		end else begin
			serial_port_clock_out  <= 1'b0;
			serial_port_data_out   <= 1'b0;
			serial_port_clock_oe_n <= ~(port_use & engine_clock_pull_low);
			serial_port_data_oe_n  <= ~(port_use & engine_data_pull_low);
		end
	end

	// sticky record that the test input was ever seen high
	always_ff @(posedge aclk) begin
		if (!aresetn) test_seen_r <= 1'b0;
		else if (test_s) test_seen_r <= 1'b1;
	end

	logic [31:0] status_w;

	assign status_w = {
		24'h00_0000,
		test_seen_r,
		self_powered,
		supply_s,
		osc_ext_clock,
		cfg_reserved_error,
		cfg_valid,
		cfg_method
	};

	assign rd_ok = 1'b1;
	assign rd_data =
		(rd_word == hcs_pkg::OFS_CTRL)    ? {31'h0000_0000, port_en_r} :
		(rd_word == hcs_pkg::OFS_STATUS)  ? status_w :
		(rd_word == hcs_pkg::OFS_SLVADDR) ? {25'h000_0000, hcs_pkg::SMBUS_SLAVE_ADDR} :
		32'(hcs_pkg::OSC_REF_HZ);

	sequence s_sample;
		state_r == hcs_pkg::ST_SAMPLE;
	endsequence

	sequence s_sample_code(logic b1, logic b0);
		state_r == hcs_pkg::ST_SAMPLE && sel1_s == b1 && sel0_s == b0;
	endsequence

	a_capture_bit0: assert property (s_sample |=> cfg_method[0] == $past(sel0_s))
		else $error("select bit0 not captured");
	a_capture_bit1: assert property (s_sample |=> cfg_method[1] == $past(sel1_s) && cfg_valid)
		else $error("select bit1 not captured");
	a_smbus_addr: assert property (s_sample_code(1'b0, 1'b1) |-> ##2 smbus_slave_mode
		&& smbus_slave_addr == hcs_pkg::SMBUS_SLAVE_ADDR && !eeprom_cfg_mode)
		else $error("smbus slave mode or address wrong");
	a_default_quiet: assert property (default_cfg_mode |-> serial_port_clock_oe_n
		&& serial_port_data_oe_n)
		else $error("serial port driven in default mode");
	a_eeprom_mode: assert property (s_sample_code(1'b1, 1'b1) |-> ##2 eeprom_cfg_mode
		&& !default_cfg_mode)
		else $error("eeprom mode not selected");
	a_reserved_flag: assert property (s_sample_code(1'b0, 1'b0) |-> ##2 cfg_reserved_error
		&& !smbus_slave_mode)
		else $error("reserved code not flagged");
	a_osc_select: assert property (s_sample |=> osc_ext_clock == $past(extclk_s)
		&& osc_amp_enable != osc_ext_clock)
		else $error("clock source select wrong");
	a_self_power: assert property (default_cfg_mode |=> self_powered == $past(supply_s)
		&& current_sense_ganged == $past(supply_s))
		else $error("self power not from supply detect");
	a_port_release: assert property (state_r != hcs_pkg::ST_ACTIVE |=> serial_port_clock_oe_n
		&& serial_port_data_oe_n)
		else $error("serial port driven while sampling");
endmodule

// ===== testbench/hcs_board_model.sv
// board straps and open-drain serial lines around the strap block
`timescale 1ns/1ps
module hcs_board_model (
	input  wire logic [1:0] strap_code,
	input  wire logic       ext_req,
	input  wire logic       supply_req,
	input  wire logic       clk_oe_n,
	input  wire logic       data_oe_n,
	output logic            scl_lvl,
	output logic            sda_lvl,
	output logic            sel1_lvl,
	output logic            ext_lvl,
	output logic            supply_lvl,
	output logic            test_lvl
);
	// strap resistor sets the released clock line level
	assign scl_lvl    = clk_oe_n ? strap_code[0] : 1'b0;
	// pull-up on the data line
	assign sda_lvl    = data_oe_n ? 1'b1 : 1'b0;
	assign sel1_lvl   = strap_code[1];
	assign ext_lvl    = ext_req;
	assign supply_lvl = supply_req;
	assign test_lvl   = 1'b0;
endmodule

// ===== testbench/hub_config_strap_select_tb_top.sv
// self-checking bench for the config strap block
`timescale 1ns/1ps
module hub_config_strap_select_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp, cfg_method;
	wire logic [31:0] s_axi_rdata;
	logic [1:0]  code = 2'h2;
	logic        ext = 1'b0, supply = 1'b0, pulls = 1'b0, dl_self = 1'b0, dl_gang = 1'b0;
	wire logic   scl, sda, sel1, ext_l, sup_l, tst, scl_oe_n, sda_oe_n, scl_do, sda_do;
	wire logic   serial_clock_rx, serial_data_rx, cfg_valid, smbus_slave_mode;
	wire logic   default_cfg_mode, eeprom_cfg_mode, cfg_reserved_error;
	wire logic   osc_ext_clock, osc_amp_enable, self_powered, current_sense_ganged;
	wire logic [6:0] smbus_slave_addr;
	int          mismatches = 0;
	int          compares = 0;

	initial begin
		forever #50 aclk = ~aclk;
	end

	hcs_board_model u_board (.strap_code(code), .ext_req(ext), .supply_req(supply),
		.clk_oe_n(scl_oe_n), .data_oe_n(sda_oe_n), .scl_lvl(scl), .sda_lvl(sda),
		.sel1_lvl(sel1), .ext_lvl(ext_l), .supply_lvl(sup_l), .test_lvl(tst));

	hcs_strap_select u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.serial_port_clock_in(scl), .serial_port_clock_out(scl_do),
		.serial_port_clock_oe_n(scl_oe_n), .serial_port_data_in(sda),
		.serial_port_data_out(sda_do), .serial_port_data_oe_n(sda_oe_n),
		.config_method_bit1(sel1), .ext_clock_select(ext_l), .local_supply_detect(sup_l),
		.test_pin(tst), .engine_clock_pull_low(pulls), .engine_data_pull_low(pulls),
		.dl_self_powered(dl_self), .dl_current_ganged(dl_gang), .serial_clock_rx,
		.serial_data_rx, .cfg_method, .cfg_valid, .smbus_slave_mode, .smbus_slave_addr,
		.default_cfg_mode, .eeprom_cfg_mode, .cfg_reserved_error, .osc_ext_clock,
		.osc_amp_enable, .self_powered, .current_sense_ganged);

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		chk("bvalid", 32'h1, s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		chk("rvalid", 32'h1, s_axi_rvalid);
		d = s_axi_rdata;
		chk("rresp", hcs_pkg::RESP_OKAY, s_axi_rresp);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic do_rst(input logic [1:0] c, input logic e);
		pulls <= 1'b0;
		code <= c;
		ext <= e;
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
	endtask

	// every code, with the clock strap set to code bit0, then the serial port gate
	task automatic t_codes;
		logic [31:0] d;
		logic [1:0]  c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			do_rst(c, c[0]);
			chk("cfg_method", {30'h0, c}, {30'h0, cfg_method});
			chk("cfg_valid", 32'h1, cfg_valid);
			chk("smbus_mode", c == 2'h1, smbus_slave_mode);
			chk("smbus_addr", (c == 2'h1) ? 7'h2c : 7'h00, smbus_slave_addr);
			chk("default_mode", c == 2'h2, default_cfg_mode);
			chk("eeprom_mode", c == 2'h3, eeprom_cfg_mode);
			chk("rsvd_error", c == 2'h0, cfg_reserved_error);
			chk("osc_ext", c[0], osc_ext_clock);
			chk("osc_amp", !c[0], osc_amp_enable);
			chk("port_out", 32'h0, {30'h0, scl_do, sda_do});
			axi_rd(hcs_pkg::OFS_STATUS, d);
			chk("status", {27'h0, c[0], c == 2'h0, 1'b1, c}, d & 32'h1f);
			pulls <= 1'b1;
			repeat (3) @(posedge aclk);
			chk("scl_oe_n", !c[0], scl_oe_n);
			chk("sda_oe_n", !c[0], sda_oe_n);
		end
	endtask

	// eeprom mode left pulling both lines; disable and re-enable the port
	task automatic t_port;
		logic [1:0] r;
		repeat (3) @(posedge aclk);
		chk("scl_rx", 32'h0, serial_clock_rx);
		chk("sda_rx", 32'h0, serial_data_rx);
		axi_wr(hcs_pkg::OFS_CTRL, 32'h0000_0000, r);
		chk("bresp_ctrl", hcs_pkg::RESP_OKAY, r);
		repeat (2) @(posedge aclk);
		chk("oe_n_off", 32'h1, scl_oe_n & sda_oe_n);
		axi_wr(hcs_pkg::OFS_CTRL, 32'h0000_0001, r);
		repeat (2) @(posedge aclk);
		chk("oe_n_on", 32'h0, scl_oe_n | sda_oe_n);
		pulls <= 1'b0;
		repeat (5) @(posedge aclk);
		chk("scl_rx_idle", 32'h1, serial_clock_rx);
	endtask

	// supply detect in default mode, downloaded bits after a resample
	task automatic t_power;
		logic [31:0] d;
		logic [1:0]  r;
		do_rst(2'h2, 1'b0);
		for (int s = 0; s < 2; s++) begin
			supply <= s[0];
			repeat (5) @(posedge aclk);
			chk("self_powered", s[0], self_powered);
			chk("ganged", s[0], current_sense_ganged);
			axi_rd(hcs_pkg::OFS_STATUS, d);
			chk("status_supply", {30'h0, s[0], s[0]}, {30'h0, d[6:5]});
			chk("status_test", 32'h0, d[7]);
		end
		code <= 2'h3;
		dl_gang <= 1'b1;
		// new strap must clear the synchroniser before the resample edge
		repeat (3) @(posedge aclk);
		axi_wr(hcs_pkg::OFS_CTRL, 32'h0000_0003, r);
		repeat (5) @(posedge aclk);
		chk("resample_code", 32'h3, {30'h0, cfg_method});
		chk("resample_eeprom", 32'h1, eeprom_cfg_mode);
		chk("dl_self", 32'h0, self_powered);
		chk("dl_gang", 32'h1, current_sense_ganged);
	endtask

	// fixed registers and refused writes
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(hcs_pkg::OFS_CTRL, d);
		chk("ctrl", 32'h0000_0001, d);
		axi_rd(hcs_pkg::OFS_SLVADDR, d);
		chk("slvaddr", 32'h0000_002c, d);
		axi_rd(hcs_pkg::OFS_REFCLK, d);
		chk("refclk", 32'h016e_3600, d);
		axi_wr(hcs_pkg::OFS_STATUS, 32'h0000_00ff, r);
		chk("bresp_ro", hcs_pkg::RESP_SLVERR, r);
		axi_wr(hcs_pkg::OFS_REFCLK, 32'h0000_0000, r);
		chk("bresp_ro2", hcs_pkg::RESP_SLVERR, r);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		t_power();
		t_codes();
		t_port();
		t_regs();
		results();
	end

	initial begin
		repeat (3000) @(posedge aclk);
		mismatches++;
		results();
	end
endmodule
